// ===== common/pitmr_pkg.sv
// Notes on behaviour
// - Wrap from modulo to zero sets overflow flag.
// - Flag clears by status read then zero write.
// - Overflow between read and write keeps flag.
// - Writing one ignored; reset clears flag.
// - Interrupt enable bit, reset clear, gates requests.
// - Halt bit freezes counter; reset sets it.
// - Clear bit resets counter and prescaler, reads zero.
// - Halt plus clear together stops at zero.
// - Prescale codes divide by 1..64; 111 is 64.
// - High read latches low byte until low read.
// - Reset and clear bit zero the counter.
// - Match modulo sets flag, restarts from zero.
// - Modulo high write blocks flag until low write.
// - Reset sets modulo bytes to all ones.
// - Software clears counter before writing modulo.
// - Software keeps halt clear before wait if needed.
// - Break-time high read needs low read before exit.
// - Debug break halts the counter.
// - Counter reads never disturb counting.
// - Stop mode freezes timer, keeps all state.
package pitmr_pkg;
  // ==========================================================
  // Register map (byte addresses on the register port)
  localparam logic [7:0] ADDR_STATUS_CONTROL = 8'h4b;
  localparam logic [7:0] ADDR_COUNT_HIGH     = 8'h4c;
  localparam logic [7:0] ADDR_COUNT_LOW      = 8'h4d;
  localparam logic [7:0] ADDR_MODULO_HIGH    = 8'h4e;
  localparam logic [7:0] ADDR_MODULO_LOW     = 8'h4f;
  // ==========================================================
  // Status/control field positions
  localparam int BIT_OVERFLOW_FLAG = 7;
  localparam int BIT_IRQ_ENABLE    = 6;
  localparam int BIT_HALT          = 5;
  localparam int BIT_CLEAR         = 4;
  localparam int PRESCALE_MSB      = 2;
  // ==========================================================
  // Reset values and limits
  localparam logic [7:0] MODULO_RESET   = 8'hff;
  localparam logic [2:0] PRESCALE_RESET = 3'h0;
  localparam logic [2:0] PRESCALE_MAX   = 3'h6;
  localparam logic [15:0] COUNT_RESET   = 16'h0000;
endpackage

// ===== common/pitmr_if.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Register port between host and timer
interface pitmr_if;
  logic       sel;    // Access strobe, one cycle
  logic       wr;     // High for write, low for read
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;  // Valid the cycle after a read strobe
  logic       irq;

  modport device (input sel, input wr, input addr, input wdata, output rdata, output irq);
  modport host (output sel, output wr, output addr, output wdata, input rdata, input irq);
endinterface
`default_nettype wire

// ===== src/pitmr_device.sv
`timescale 1ns/1ps
`default_nettype none
module pitmr_device (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic debug_break,
  input  wire logic stop_mode,
  pitmr_if.device   bus
);
  // ==========================================================
  // Decode
  wire rd_stb  = bus.sel & ~bus.wr;
  wire wr_stb  = bus.sel & bus.wr;
  wire is_sc   = bus.addr == pitmr_pkg::ADDR_STATUS_CONTROL;
  wire is_cnth = bus.addr == pitmr_pkg::ADDR_COUNT_HIGH;
  wire is_cntl = bus.addr == pitmr_pkg::ADDR_COUNT_LOW;
  wire is_modh = bus.addr == pitmr_pkg::ADDR_MODULO_HIGH;
  wire is_modl = bus.addr == pitmr_pkg::ADDR_MODULO_LOW;
  wire wr_sc   = wr_stb & is_sc;
  wire clr_req = wr_sc & bus.wdata[pitmr_pkg::BIT_CLEAR];

  logic        overflow_flag, overflow_irq_enable, counter_halt, clear_armed, mod_lock;
  logic        cnt_latched;
  logic [2:0]  prescale_select;
  logic [5:0]  prescaler;
  logic [15:0] count, modulo;
  logic [7:0]  low_latch, rdata_q;

  // ==========================================================
  // Prescaler tap; code 111 shares the divide-by-64 tap
  wire [2:0] tap = (prescale_select > pitmr_pkg::PRESCALE_MAX) ?
                   pitmr_pkg::PRESCALE_MAX : prescale_select;
  wire [6:0] pre_mask = 7'(7'h7f >> (7 - {4'h0, tap}));
  wire frozen  = counter_halt | debug_break | stop_mode;
  wire tick    = ~frozen & ((prescaler & pre_mask[5:0]) == pre_mask[5:0]);
  wire match   = count == modulo;
  wire wrap    = tick & match & ~clr_req;
  wire set_ovf = wrap & ~mod_lock;
  wire clr_ovf = wr_sc & clear_armed & ~bus.wdata[pitmr_pkg::BIT_OVERFLOW_FLAG];

  // Prescaler and counter; clear wins over counting
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prescaler <= 6'h00;
      count     <= pitmr_pkg::COUNT_RESET;
    end else if (clr_req) begin
      prescaler <= 6'h00;
      count     <= pitmr_pkg::COUNT_RESET;
    end else if (!frozen) begin
      prescaler <= prescaler + 6'h01;
      if (tick) count <= match ? pitmr_pkg::COUNT_RESET : count + 16'h0001;
    end
  end

  // Control bits; clear bit is never stored so it reads zero
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      overflow_irq_enable <= 1'b0;
      counter_halt        <= 1'b1;
      prescale_select     <= pitmr_pkg::PRESCALE_RESET;
    end else if (wr_sc) begin
      overflow_irq_enable <= bus.wdata[pitmr_pkg::BIT_IRQ_ENABLE];
      counter_halt        <= bus.wdata[pitmr_pkg::BIT_HALT];
      prescale_select     <= bus.wdata[pitmr_pkg::PRESCALE_MSB:0];
    end
  end

  // Overflow flag: arm on read while set; a new overflow disarms, set beats clear
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      overflow_flag <= 1'b0;
      clear_armed   <= 1'b0;
    end else begin
      if (set_ovf) overflow_flag <= 1'b1;
      else if (clr_ovf) overflow_flag <= 1'b0;
      if (set_ovf || wr_sc) clear_armed <= 1'b0;
      else if (rd_stb && is_sc && overflow_flag) clear_armed <= 1'b1;
    end
  end

  // Modulo bytes with high-write interlock
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      modulo   <= {pitmr_pkg::MODULO_RESET, pitmr_pkg::MODULO_RESET};
      mod_lock <= 1'b0;
    end else if (wr_stb && is_modh) begin
      modulo[15:8] <= bus.wdata;
      mod_lock     <= 1'b1;
    end else if (wr_stb && is_modl) begin
      modulo[7:0] <= bus.wdata;
      mod_lock    <= 1'b0;
    end
  end

  // Low byte latch; reads only sample, never steer the count
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_latched <= 1'b0;
      low_latch   <= 8'h00;
    end else if (rd_stb && is_cnth && !cnt_latched) begin
      cnt_latched <= 1'b1;
      low_latch   <= count[7:0];
    end else if (rd_stb && is_cntl) begin
      cnt_latched <= 1'b0;
    end
  end

  // ==========================================================
  // Read data
  wire [7:0] sc_read = {overflow_flag, overflow_irq_enable, counter_halt, 1'b0, 1'b0,
                        prescale_select};
  wire [7:0] low_read = cnt_latched ? low_latch : count[7:0];
  wire [7:0] next_rdata = is_sc   ? sc_read :
                          is_cnth ? count[15:8] :
                          is_cntl ? low_read :
                          is_modh ? modulo[15:8] :
                          is_modl ? modulo[7:0] : 8'h00;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) rdata_q <= 8'h00;
    else if (rd_stb) rdata_q <= next_rdata;
  end

  assign bus.rdata = rdata_q;
  assign bus.irq   = overflow_flag & overflow_irq_enable;
endmodule
`default_nettype wire

// ===== src/pitmr_host.sv
`timescale 1ns/1ps
`default_nettype none
module pitmr_host (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       req,
  input  wire logic       req_wr,
  input  wire logic [7:0] req_addr,
  input  wire logic [7:0] req_wdata,
  output logic            done,
  output logic [7:0]      rsp_rdata,
  output logic            irq,
  pitmr_if.host           bus
);
  // ==========================================================
  // One access per request; read data returns two cycles later.
  // Ordering of accesses is the caller's duty.
  logic       sel_q, wr_q, pend;
  logic [7:0] addr_q, wdata_q;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sel_q   <= 1'b0;
      wr_q    <= 1'b0;
      addr_q  <= 8'h00;
      wdata_q <= 8'h00;
    end else begin
      sel_q <= req;
      if (req) begin
        wr_q    <= req_wr;
        addr_q  <= req_addr;
        wdata_q <= req_wdata;
      end
    end
  end

  // Answer one cycle after the strobe, when the device data is valid
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pend      <= 1'b0;
      rsp_rdata <= 8'h00;
    end else begin
      pend <= sel_q;
      if (pend) rsp_rdata <= bus.rdata;
    end
  end

  assign done      = pend;
  assign irq       = bus.irq;
  assign bus.sel   = sel_q;
  assign bus.wr    = wr_q;
  assign bus.addr  = addr_q;
  assign bus.wdata = wdata_q;
endmodule
`default_nettype wire

// ===== verif/pitmr_chk.sv
`timescale 1ns/1ps
`default_nettype none
module pitmr_chk (
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic       sel,
  input wire logic       wr,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic       irq
);
  // ==========================================================
  // Shadows of the writable registers, reset as the device resets
  logic [7:0] ctl;
  logic [7:0] mh;
  logic [7:0] ml;
  wire logic  rd = sel && !wr;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctl <= 8'h20;
      mh  <= 8'hff;
      ml  <= 8'hff;
    end else begin
      if (sel && wr && addr == 8'h4b) ctl <= wdata;
      if (sel && wr && addr == 8'h4e) mh <= wdata;
      if (sel && wr && addr == 8'h4f) ml <= wdata;
    end
  end
  // ==========================================================
  // Bus relations, judged one cycle after the strobe
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence ctl_rd;
    rd && addr == 8'h4b;
  endsequence
  pulse_len_a: assert property (sel |=> !sel) else $error("strobe too long");
  unmapped_zero_a: assert property (rd && (addr < 8'h4b || addr > 8'h4f) |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  clear_reads_zero_a: assert property (ctl_rd |=> rdata[4:3] == 2'h0)
    else $error("clear bit not zero");
  ctl_readback_a: assert property (ctl_rd |=> rdata[6:5] == ctl[6:5] && rdata[2:0] == ctl[2:0])
    else $error("control readback wrong");
  mod_high_a: assert property (rd && addr == 8'h4e |=> rdata == mh)
    else $error("modulo high readback wrong");
  mod_low_a: assert property (rd && addr == 8'h4f |=> rdata == ml)
    else $error("modulo low readback wrong");
  irq_mask_a: assert property (sel && wr && addr == 8'h4b && !wdata[6] |=> !irq)
    else $error("request not masked");
  rdata_hold_a: assert property (!rd |=> $stable(rdata)) else $error("read data moved");
endmodule
`default_nettype wire

// ===== verif/test_periodic_interrupt_timer.sv
`timescale 1ns/1ps
`default_nettype none
module test_periodic_interrupt_timer;
  logic       ref_clk = 1'b0;
  logic       rst = 1'b1;
  logic       req = 1'b0;
  logic       req_wr = 1'b0;
  logic       debug_break = 1'b0;
  logic       stop_mode = 1'b0;
  logic [7:0] req_addr = 8'h00;
  logic [7:0] req_wdata = 8'h00;
  logic       done;
  logic       irq;
  logic [7:0] rsp_rdata;
  logic [7:0] rd;
  int         num_errors = 0;
  int         samples_checked = 0;
  int         cyc = 0;
  int         t1;
  int         c;
  pitmr_if bus_if ();
  pitmr_device i_pitmr_device (.ref_clk(ref_clk), .rst(rst), .debug_break(debug_break),
    .stop_mode(stop_mode), .bus(bus_if));
  pitmr_host i_pitmr_host (.ref_clk(ref_clk), .rst(rst), .req(req), .req_wr(req_wr),
    .req_addr(req_addr), .req_wdata(req_wdata), .done(done), .rsp_rdata(rsp_rdata),
    .irq(irq), .bus(bus_if));
  pitmr_chk i_pitmr_chk (.ref_clk(ref_clk), .rst(rst), .sel(bus_if.sel), .wr(bus_if.wr),
    .addr(bus_if.addr), .wdata(bus_if.wdata), .rdata(bus_if.rdata), .irq(bus_if.irq));
  // ==========================================================
  // Clock and a cycle count for period measurement
  initial forever #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc <= cyc + 1;
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  // One access; sampled 1 ns after the edge so done has settled
  task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge ref_clk);
    req <= 1'b1;
    req_wr <= w;
    req_addr <= a;
    req_wdata <= d;
    @(posedge ref_clk);
    req <= 1'b0;
    do begin
      @(posedge ref_clk);
      #1;
      k++;
    end while (done !== 1'b1 && k < 8);
    // The host registers the read data one edge after done
    @(posedge ref_clk);
    #1;
    rd = rsp_rdata;
  endtask
  task rchk(input logic [7:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, rd});
  endtask
  // Bounded wait: slowest overflow period is 2048 cycles
  task wait_irq;
    int k;
    k = 0;
    while (irq !== 1'b1 && k < 4000) begin
      @(posedge ref_clk);
      #1;
      k++;
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ==========================================================
  // Watchdog well past the expected 13k cycles
  initial begin
    #1000000;
    num_errors++;
    end_sim();
  end
  // ==========================================================
  // Main sequence
  initial begin
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    rchk(8'h4b, 8'h20);
    rchk(8'h4c, 8'h00);
    rchk(8'h4d, 8'h00);
    rchk(8'h4e, 8'hff);
    rchk(8'h4f, 8'hff);
    acc(1'b1, 8'h50, 8'h55);
    rchk(8'h50, 8'h00);
    acc(1'b1, 8'h4b, 8'ha0);
    rchk(8'h4b, 8'h20);
    $display("test reset done");
    acc(1'b1, 8'h4b, 8'h30);
    acc(1'b1, 8'h4e, 8'h00);
    acc(1'b1, 8'h4b, 8'h00);
    repeat (300) @(posedge ref_clk);
    rchk(8'h4b, 8'h00);
    acc(1'b1, 8'h4b, 8'h30);
    acc(1'b1, 8'h4f, 8'h00);
    acc(1'b1, 8'h4b, 8'h00);
    rchk(8'h4b, 8'h80);
    acc(1'b1, 8'h4b, 8'h00);
    rchk(8'h4b, 8'h80);
    acc(1'b1, 8'h4b, 8'h30);
    repeat (20) @(posedge ref_clk);
    rchk(8'h4d, 8'h00);
    rchk(8'h4b, 8'ha0);
    acc(1'b1, 8'h4b, 8'h20);
    rchk(8'h4b, 8'h20);
    $display("test flag done");
    // Overflow period is (modulo + 1) times the divide ratio
    acc(1'b1, 8'h4e, 8'h00);
    acc(1'b1, 8'h4f, 8'h1f);
    for (c = 0; c < 8; c++) begin
      acc(1'b1, 8'h4b, 8'h70 | c[2:0]);
      acc(1'b0, 8'h4b, 8'h00);
      acc(1'b1, 8'h4b, 8'h60 | c[2:0]);
      chk("irq", 16'h0000, {15'h0000, irq});
      acc(1'b1, 8'h4b, 8'h40 | c[2:0]);
      wait_irq();
      t1 = cyc;
      acc(1'b0, 8'h4b, 8'h00);
      acc(1'b1, 8'h4b, 8'h40 | c[2:0]);
      wait_irq();
      chk("period", 16'(32 << (c > 6 ? 6 : c)), 16'(cyc - t1));
    end
    $display("test prescale done");
    acc(1'b1, 8'h4b, 8'h16);
    rchk(8'h4c, 8'h00);
    repeat (200) @(posedge ref_clk);
    rchk(8'h4c, 8'h00);
    rchk(8'h4d, 8'h00);
    // Freeze inputs raised while halted, so no count slips in before the freeze holds
    for (c = 0; c < 2; c++) begin
      acc(1'b1, 8'h4b, 8'h30);
      @(posedge ref_clk);
      debug_break <= (c == 0);
      stop_mode <= (c == 1);
      acc(1'b1, 8'h4b, 8'h00);
      repeat (20) @(posedge ref_clk);
      rchk(8'h4d, 8'h00);
      debug_break <= 1'b0;
      stop_mode <= 1'b0;
    end
    $display("test latch done");
    end_sim();
  end
endmodule
`default_nettype wire
